// ### hw/dlp_config_regs.v
// Summary of operation
// RULE_01 - Shuffle bit set selects MSB shuffling, clear selects thermometer; resets clear.
// RULE_02 - Decode select 00 NRZ, 01 second-Nyquist mixing, 10 RZ; 11 reserved.
// RULE_03 - Master power-down powers off all eight lanes and bias; resets to one.
// RULE_04 - Per-lane power-down, bit n powers off lane n; resets to zero.
// RULE_05 - Bit 1 of sync power register powers off sync request buffer.
// RULE_06 - Pad setting: slew from bits 1:0, drive from bits 3:2; resets 0xf.
// RULE_07 - Recovery reset bit zero holds lane control logic in reset; resets one.
// RULE_08 - Read-only reserved bits read zero; writable bits read back last accepted write (reserved decode code 11 is refused).
`timescale 1ns/100ps
`default_nettype none
`include "dlp_consts.vh"

module dlp_config_regs (
    input wire clk,
    input wire rst,
    input wire spi_cs_n,
    input wire spi_sclk,
    input wire spi_sdi,
    output reg spi_sdo,
    output wire spi_sdo_oe,
    output wire shuffle_enable,
    output wire [1:0] decode_mode,
    output wire [1:0] port_pad_slew,
    output wire [1:0] port_pad_drive,
    output wire receiver_master_powerdown,
    output wire [`DLP_LANES-1:0] lane_powerdown,
    output wire bias_powerdown,
    output wire sync_buffer_powerdown_bit,
    output wire lane_recovery_logic_reset
);

    // Control-port state
    reg sclk_q;
    reg [4:0] bit_cnt;
    reg [15:0] shift_in;
    reg [15:0] instr;
    reg load_tx;
    reg [7:0] tx;
    reg wr_en;
    reg [7:0] wr_data;

    // Register storage
    reg [7:0] coding_reg;
    reg [7:0] nyquist_reg;
    reg [7:0] pad_reg;
    reg [7:0] lane_receiver_master_powerdown_reg;
    reg [7:0] lane_pd_reg;
    reg [7:0] sync_pd_reg;
    reg [7:0] cdr_rst_reg;

    wire sclk_rise;
    wire sclk_fall;
    wire is_read;
    wire [`DLP_ADDR_W-1:0] cur_addr;
    wire [2:0] cur_sel;
    reg [7:0] rd_value;

    function [2:0] addr_select;
        input [`DLP_ADDR_W-1:0] addr;
        begin
            if (addr == `DLP_ADDR_CODING) begin
                addr_select = `DLP_SEL_CODING;
            end else if (addr == `DLP_ADDR_NYQUIST) begin
                addr_select = `DLP_SEL_NYQUIST;
            end else if (addr == `DLP_ADDR_PAD) begin
                addr_select = `DLP_SEL_PAD;
            end else if (addr == `DLP_ADDR_LANE_RECEIVER_MASTER_POWERDOWN) begin
                addr_select = `DLP_SEL_LANE_RECEIVER_MASTER_POWERDOWN;
            end else if (addr == `DLP_ADDR_LANE_PD) begin
                addr_select = `DLP_SEL_LANE_PD;
            end else if (addr == `DLP_ADDR_SYNC_PD) begin
                addr_select = `DLP_SEL_SYNC_PD;
            end else if (addr == `DLP_ADDR_CDR_RST) begin
                addr_select = `DLP_SEL_CDR_RST;
            end else begin
                addr_select = `DLP_SEL_NONE;
            end
        end
    endfunction

    assign sclk_rise = spi_sclk & ~sclk_q & ~spi_cs_n;
    assign sclk_fall = ~spi_sclk & sclk_q & ~spi_cs_n;
    assign is_read = instr[`DLP_RW_BIT];
    assign cur_addr = instr[`DLP_ADDR_W-1:0];
    assign cur_sel = addr_select(cur_addr);

    // Pad drives only during the data byte of a read
    assign spi_sdo_oe = ~spi_cs_n & is_read &
                        (bit_cnt >= `DLP_INSTR_BITS) & (bit_cnt < `DLP_FRAME_BITS);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi_sclk;
        end
    end

    // Bit counter; bits past one byte of data are ignored
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 5'h00;
        end else if (spi_cs_n) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise && bit_cnt != `DLP_FRAME_BITS) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_in <= 16'h0000;
        end else if (sclk_rise && bit_cnt != `DLP_FRAME_BITS) begin
            shift_in <= {shift_in[14:0], spi_sdi};
        end
    end

    // Instruction latch and read-data load request
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            instr <= 16'h0000;
            load_tx <= 1'b0;
        end else begin
            load_tx <= 1'b0;
            if (spi_cs_n) begin
                instr <= 16'h0000;
            end else if (sclk_rise && bit_cnt == `DLP_INSTR_LAST) begin
                instr <= {shift_in[14:0], spi_sdi};
                load_tx <= 1'b1;
            end
        end
    end

    // Write strobe after the last data bit of a write frame
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_en <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            wr_en <= sclk_rise & (bit_cnt == `DLP_DATA_LAST) & ~is_read;
            if (sclk_rise && bit_cnt == `DLP_DATA_LAST) begin
                wr_data <= {shift_in[6:0], spi_sdi};
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        rd_value = 8'h00;
        case (cur_sel)
            `DLP_SEL_CODING: rd_value = coding_reg; // RULE_08
            `DLP_SEL_NYQUIST: rd_value = nyquist_reg;
            `DLP_SEL_PAD: rd_value = pad_reg;
            `DLP_SEL_LANE_RECEIVER_MASTER_POWERDOWN: rd_value = lane_receiver_master_powerdown_reg;
            `DLP_SEL_LANE_PD: rd_value = lane_pd_reg;
            `DLP_SEL_SYNC_PD: rd_value = sync_pd_reg;
            `DLP_SEL_CDR_RST: rd_value = cdr_rst_reg;
            default: rd_value = 8'h00;
        endcase
    end

    // Read data shifts out MSB first on falling edges
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx <= 8'h00;
        end else if (load_tx) begin
            tx <= rd_value;
        end else if (sclk_fall && bit_cnt > `DLP_INSTR_BITS) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            spi_sdo <= 1'b0;
        end else if (load_tx) begin
            spi_sdo <= rd_value[7];
        end else if (sclk_fall && bit_cnt > `DLP_INSTR_BITS) begin
            spi_sdo <= tx[6];
        end
    end

    // Register writes; read-only bits masked off
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            coding_reg <= `DLP_RST_CODING; // RULE_01
            nyquist_reg <= `DLP_RST_NYQUIST; // RULE_02
            pad_reg <= `DLP_RST_PAD; // RULE_06
            lane_receiver_master_powerdown_reg <= `DLP_RST_LANE_RECEIVER_MASTER_POWERDOWN; // RULE_03
            lane_pd_reg <= `DLP_RST_LANE_PD; // RULE_04
            sync_pd_reg <= `DLP_RST_SYNC_PD; // RULE_05
            cdr_rst_reg <= `DLP_RST_CDR_RST; // RULE_07
        end else if (wr_en) begin
            case (cur_sel)
                `DLP_SEL_CODING: begin
                    coding_reg <= wr_data & `DLP_MASK_CODING; // RULE_08
                end
                `DLP_SEL_NYQUIST: begin
                    // Reserved decode code is refused, old mode kept
                    if (wr_data[1:0] != `DLP_MODE_RESERVED) begin
                        nyquist_reg <= wr_data & `DLP_MASK_NYQUIST; // RULE_02
                    end
                end
                `DLP_SEL_PAD: begin
                    pad_reg <= wr_data & `DLP_MASK_PAD; // RULE_08
                end
                `DLP_SEL_LANE_RECEIVER_MASTER_POWERDOWN: begin
                    lane_receiver_master_powerdown_reg <= wr_data & `DLP_MASK_LANE_RECEIVER_MASTER_POWERDOWN; // RULE_08
                end
                `DLP_SEL_LANE_PD: begin
                    lane_pd_reg <= wr_data & `DLP_MASK_LANE_PD; // RULE_08
                end
                `DLP_SEL_SYNC_PD: begin
                    sync_pd_reg <= wr_data & `DLP_MASK_SYNC_PD; // RULE_08
                end
                `DLP_SEL_CDR_RST: begin
                    cdr_rst_reg <= wr_data & `DLP_MASK_CDR_RST; // RULE_08
                end
                default: begin
                end
            endcase
        end
    end

    // Core and pad controls straight from register bits
    assign shuffle_enable = coding_reg[`DLP_SHUFFLE_BIT]; // RULE_01
    assign decode_mode = nyquist_reg[1:0]; // RULE_02
    assign port_pad_slew = pad_reg[1:0]; // RULE_06
    assign port_pad_drive = pad_reg[3:2]; // RULE_06
    assign receiver_master_powerdown = lane_receiver_master_powerdown_reg[`DLP_LANE_RECEIVER_MASTER_POWERDOWN_BIT]; // RULE_03
    assign sync_buffer_powerdown_bit = sync_pd_reg[`DLP_SYNC_PD_BIT]; // RULE_05
    assign lane_recovery_logic_reset = ~cdr_rst_reg[`DLP_CDR_RUN_BIT]; // RULE_07

    dlp_lane_power u_lane_power (
        .clk(clk),
        .rst(rst),
        .receiver_master_powerdown(receiver_master_powerdown),
        .lane_powerdown_override(lane_pd_reg),
        .lane_powerdown(lane_powerdown),
        .bias_powerdown(bias_powerdown)
    );

endmodule // dlp_config_regs

`default_nettype wire

// ### hw/dlp_consts.vh
`ifndef DLP_CONSTS_VH
`define DLP_CONSTS_VH

// Control-port framing
`define DLP_ADDR_W 15
`define DLP_INSTR_LAST 5'd15
`define DLP_INSTR_BITS 5'd16
`define DLP_DATA_LAST 5'd23
`define DLP_FRAME_BITS 5'd24
`define DLP_RW_BIT 15

// Register addresses
`define DLP_ADDR_CODING 15'h0151
`define DLP_ADDR_NYQUIST 15'h0152
`define DLP_ADDR_PAD 15'h01df
`define DLP_ADDR_LANE_RECEIVER_MASTER_POWERDOWN 15'h0200
`define DLP_ADDR_LANE_PD 15'h0201
`define DLP_ADDR_SYNC_PD 15'h0203
`define DLP_ADDR_CDR_RST 15'h0206

// Internal register selects
`define DLP_SEL_NONE 3'h0
`define DLP_SEL_CODING 3'h1
`define DLP_SEL_NYQUIST 3'h2
`define DLP_SEL_PAD 3'h3
`define DLP_SEL_LANE_RECEIVER_MASTER_POWERDOWN 3'h4
`define DLP_SEL_LANE_PD 3'h5
`define DLP_SEL_SYNC_PD 3'h6
`define DLP_SEL_CDR_RST 3'h7

// Reset values
`define DLP_RST_CODING 8'h00
`define DLP_RST_NYQUIST 8'h00
`define DLP_RST_PAD 8'h0f
`define DLP_RST_LANE_RECEIVER_MASTER_POWERDOWN 8'h01
`define DLP_RST_LANE_PD 8'h00
`define DLP_RST_SYNC_PD 8'h00
`define DLP_RST_CDR_RST 8'h01

// Writable-bit masks; other bits are read-only zero
`define DLP_MASK_CODING 8'hff
`define DLP_MASK_NYQUIST 8'h03
`define DLP_MASK_PAD 8'h0f
`define DLP_MASK_LANE_RECEIVER_MASTER_POWERDOWN 8'h01
`define DLP_MASK_LANE_PD 8'hff
`define DLP_MASK_SYNC_PD 8'h03
`define DLP_MASK_CDR_RST 8'h01

// Field positions and codes
`define DLP_SHUFFLE_BIT 2
`define DLP_MODE_RESERVED 2'h3
`define DLP_LANE_RECEIVER_MASTER_POWERDOWN_BIT 0
`define DLP_SYNC_PD_BIT 1
`define DLP_CDR_RUN_BIT 0
`define DLP_LANES 8

`endif

// ### hw/dlp_lane_power.v
`timescale 1ns/100ps
`default_nettype none
`include "dlp_consts.vh"

module dlp_lane_power (
    input wire clk,
    input wire rst,
    input wire receiver_master_powerdown,
    input wire [`DLP_LANES-1:0] lane_powerdown_override,
    output reg [`DLP_LANES-1:0] lane_powerdown,
    output reg bias_powerdown
);

    genvar i;

    // Master forces every lane off; override acts per lane
    generate
        for (i = 0; i < `DLP_LANES; i = i + 1) begin : g_lane
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    lane_powerdown[i] <= 1'b1;
                end else begin
                    lane_powerdown[i] <= receiver_master_powerdown |
                                         lane_powerdown_override[i]; // RULE_03 RULE_04
                end
            end
        end
    endgenerate

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bias_powerdown <= 1'b1;
        end else begin
            bias_powerdown <= receiver_master_powerdown; // RULE_03
        end
    end

endmodule // dlp_lane_power

`default_nettype wire

// ### testbench/dac_decode_and_lane_power_config_test.sv
`timescale 1ns/100ps
`default_nettype none
module dac_decode_and_lane_power_config_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n = 1'b1;
    logic sclk = 1'b0;
    logic sdi = 1'b0;
    wire sdo, sdo_oe, shuf, bias, master, sync, recov;
    wire [1:0] mode, slew, drive;
    wire [7:0] lane;
    int n_errors = 0;
    int checks = 0;
    // Entries 7 and 8 are unmapped addresses
    logic [14:0] adr [0:8] = '{15'h151, 15'h152, 15'h1df, 15'h200, 15'h201, 15'h203,
        15'h206, 15'h150, 15'h202};
    logic [7:0] msk [0:8] = '{8'hff, 8'h03, 8'h0f, 8'h01, 8'hff, 8'h03, 8'h01, 8'h00, 8'h00};
    logic [7:0] rv [0:8] = '{8'h00, 8'h00, 8'h0f, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0] m [0:8];
    dlp_config_regs dut_u (.clk(clk), .rst(rst), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .shuffle_enable(shuf),
        .decode_mode(mode), .port_pad_slew(slew), .port_pad_drive(drive),
        .receiver_master_powerdown(master), .lane_powerdown(lane), .bias_powerdown(bias),
        .sync_buffer_powerdown_bit(sync), .lane_recovery_logic_reset(recov));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Read data is taken just before each rising serial clock
    task xfer(input logic [23:0] f, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            @(posedge clk) sclk <= 1'b0;
            sdi <= f[23-i];
            repeat (2) @(posedge clk);
            @(negedge clk) if (i >= 16) rd = {rd[6:0], sdo & sdo_oe};
            @(posedge clk) sclk <= 1'b1;
            repeat (2) @(posedge clk);
        end
        @(posedge clk) sclk <= 1'b0;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    function logic [7:0] nxt(input int k, input logic [7:0] d);
        if (k == 1 && d[1:0] == 2'h3)
            return m[k];
        return d & msk[k];
    endfunction
    task wr(input int k, input logic [7:0] d);
        logic [7:0] x;
        xfer({1'b0, adr[k], d}, 24, x);
        m[k] = nxt(k, d);
    endtask
    task rd_chk(input int k);
        logic [7:0] x;
        xfer({1'b1, adr[k], 8'h00}, 24, x);
        chk("readback", m[k], x);
    endtask
    task outs;
        chk("shuffle", {7'h0, m[0][2]}, {7'h0, shuf});
        chk("decode", {6'h0, m[1][1:0]}, {6'h0, mode});
        chk("pad", {4'h0, m[2][3:0]}, {4'h0, drive, slew});
        chk("master", {7'h0, m[3][0]}, {7'h0, master});
        chk("bias", {7'h0, m[3][0]}, {7'h0, bias});
        chk("lanes", m[4] | {8{m[3][0]}}, lane);
        chk("sync", {7'h0, m[5][1]}, {7'h0, sync});
        chk("recovery", {7'h0, ~m[6][0]}, {7'h0, recov});
    endtask
    task do_reset;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        m = rv;
        @(posedge clk);
    endtask
    initial begin
        #(50000 * 25);
        n_errors++;
        stop_test();
    end
    initial begin
        logic [7:0] x;
        int k;
        void'($urandom(32'hc3f265fc));
        do_reset();
        outs();
        for (k = 0; k < 9; k++)
            rd_chk(k);
        // Every decode code, the last one refused
        for (k = 0; k < 4; k++) begin
            wr(1, 8'hfc | k[7:0]);
            rd_chk(1);
            outs();
        end
        wr(3, 8'h00);
        wr(4, 8'ha5);
        wr(6, 8'h00);
        outs();
        // Frame cut short must not write
        xfer({1'b0, adr[0], 8'h04}, 20, x);
        rd_chk(0);
        repeat (40) begin
            k = $urandom_range(8);
            wr(k, 8'($urandom));
            rd_chk(k);
            // Idle gap so the quiet-bus check gets exercised
            repeat (4 + $urandom_range(5)) @(posedge clk);
            outs();
        end
        do_reset();
        outs();
        rd_chk(3);
        stop_test();
    end
endmodule // dac_decode_and_lane_power_config_test
bind dlp_config_regs dlp_config_regs_checker chk_u (.clk(clk), .rst(rst), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .shuffle_enable(shuffle_enable), .decode_mode(decode_mode),
    .port_pad_slew(port_pad_slew), .port_pad_drive(port_pad_drive),
    .receiver_master_powerdown(receiver_master_powerdown), .lane_powerdown(lane_powerdown),
    .bias_powerdown(bias_powerdown), .sync_buffer_powerdown_bit(sync_buffer_powerdown_bit),
    .lane_recovery_logic_reset(lane_recovery_logic_reset));
`default_nettype wire

// ### testbench/dlp_config_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dlp_config_regs_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe,
    input wire logic shuffle_enable,
    input wire logic [1:0] decode_mode,
    input wire logic [1:0] port_pad_slew,
    input wire logic [1:0] port_pad_drive,
    input wire logic receiver_master_powerdown,
    input wire logic [7:0] lane_powerdown,
    input wire logic bias_powerdown,
    input wire logic sync_buffer_powerdown_bit,
    input wire logic lane_recovery_logic_reset
);
    logic [2:0] idle;
    // Edges since select went high, saturating
    always @(posedge clk or posedge rst) begin
        if (rst)
            idle <= 3'h0;
        else if (!spi_cs_n)
            idle <= 3'h0;
        else if (idle != 3'h7)
            idle <= idle + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_values:
        assert property ($fell(rst) |-> receiver_master_powerdown && !shuffle_enable
            && decode_mode == 2'h0 && {port_pad_drive, port_pad_slew} == 4'hf)
        else $error("outputs not at reset values");
    a_bias_follows_master:
        assert property (bias_powerdown == $past(receiver_master_powerdown))
        else $error("bias power-down does not follow master");
    a_master_all_lanes:
        assert property (receiver_master_powerdown |=> lane_powerdown == 8'hff)
        else $error("master power-down left a lane up");
    a_bias_lane_tie:
        assert property (bias_powerdown |-> lane_powerdown == 8'hff)
        else $error("bias down while a lane is up");
    a_sdo_idle_off:
        assert property (spi_cs_n |-> !spi_sdo_oe)
        else $error("read driver on while deselected");
    a_cfg_quiet_idle:
        assert property (idle >= 3'h5 |-> $stable({shuffle_enable, decode_mode, port_pad_slew,
            port_pad_drive, receiver_master_powerdown, sync_buffer_powerdown_bit,
            lane_recovery_logic_reset, lane_powerdown}))
        else $error("configuration changed without a frame");
    a_decode_legal:
        assert property (decode_mode != 2'h3)
        else $error("reserved decode code reached the core");
    a_sdo_holds:
        assert property (spi_sdo_oe && $past(spi_sdo_oe) && $past(spi_sdo_oe, 2)
            && !(!spi_sclk && $past(spi_sclk))
            && !(!$past(spi_sclk) && $past(spi_sclk, 2)) |-> $stable(spi_sdo))
        else $error("read data moved without a clock fall");
    c_read: cover property ($rose(spi_sdo_oe));
    c_shuffle: cover property ($rose(shuffle_enable));
    c_master_up: cover property ($fell(receiver_master_powerdown));
endmodule // dlp_config_regs_checker
`default_nettype wire
